// >>> design/vamlpo_params.svh
// Constants for the vector ALU multiply, logic and predicate slot datapath.
// Assumes inclusion by bare name from the design include path.
`ifndef VAMLPO_PARAMS_SVH
`define VAMLPO_PARAMS_SVH

// Three-operand opcodes, low five bits of the opcode field
`define VAMLPO_OP3_U24_FMA 5'h10
`define VAMLPO_OP3_FMA_TIMES_TWO 5'h15
`define VAMLPO_OP3_FMA_TIMES_FOUR 5'h16

// Two-operand opcodes
`define VAMLPO_OP2_DEP_FMA 11'h0D4
`define VAMLPO_OP2_DEP_FMA_IEEE 11'h0D5
`define VAMLPO_OP2_SIGNED_MUL_UPPER 11'h090
`define VAMLPO_OP2_UNSIGNED_MUL_UPPER 11'h092
`define VAMLPO_OP2_SIGNED_MUL_LOWER 11'h08F
`define VAMLPO_OP2_UNSIGNED_MUL_LOWER 11'h091
`define VAMLPO_OP2_U24_MUL_UPPER 11'h0B2
`define VAMLPO_OP2_IDLE_SLOT_OP 11'h01A
`define VAMLPO_OP2_NOT 11'h033
`define VAMLPO_OP2_OR 11'h031
`define VAMLPO_OP2_NIBBLE_TO_FLOAT 11'h0B4
`define VAMLPO_OP2_PRED_COUNTER_CLEAR 11'h026
`define VAMLPO_OP2_PRED_COUNTER_INVERT 11'h024
`define VAMLPO_OP2_PRED_COUNTER_POP 11'h025
`define VAMLPO_OP2_PRED_COUNTER_RESTORE 11'h027

// Float constants
`define VAMLPO_FP_ZERO 32'h00000000
`define VAMLPO_FP_ONE 32'h3F800000
`define VAMLPO_FP_MAX 32'h7F7FFFFF
`define VAMLPO_FP_QNAN 32'h7FC00000
`define VAMLPO_FP_BIAS 11'h07F
`define VAMLPO_NIB_EXP_BASE 8'h7B

// Reset values
`define VAMLPO_RST_WORD 32'h00000000
`define VAMLPO_RST_PRED_EXEC 1'b0

`endif

// >>> design/vamlpo_pkg.sv
// Types shared by the vector ALU multiply, logic and predicate datapath.
// Assumes nothing of its surroundings.
`default_nettype none

package vamlpo_pkg;
	typedef logic [31:0] vamlpo_word_t;
	typedef logic [10:0] vamlpo_opc_t;
	typedef logic [6:0] vamlpo_gpr_addr_t;
	typedef enum logic [4:0] {
		KIND_EMPTY, KIND_IDLE, KIND_UNSUP, KIND_FMA2, KIND_FMA4, KIND_U24FMA,
		KIND_DEP, KIND_DEP_IEEE, KIND_SMULHI, KIND_UMULHI, KIND_SMULLO, KIND_UMULLO,
		KIND_U24HI, KIND_NOT, KIND_OR, KIND_NIB, KIND_CLR, KIND_INV, KIND_POP, KIND_RESTORE
	} vamlpo_kind_t;
endpackage

`default_nettype wire

// >>> design/vamlpo_fma.sv
// Single-precision fused multiply-add with power-of-two post scale.
// Assumes operands are stable for the cycle; purely combinational.
`default_nettype none

module vamlpo_fma
	import vamlpo_pkg::*;
(
	// Operands
	input wire vamlpo_word_t i_a,
	input wire vamlpo_word_t i_b,
	input wire vamlpo_word_t i_c,
	// Control
	input wire logic i_ieee_zero,
	input wire logic [1:0] i_scale,
	// Result
	output logic [31:0] o_sum
);
	`include "vamlpo_params.svh"

	logic za, zb, zc, pz, ps, swap, bigs, smalls, nan_in;
	logic [47:0] pm;
	logic [23:0] pman;
	logic signed [10:0] pe, ce, bige, re;
	logic [10:0] diff;
	logic [26:0] mp, mc, bigm, smallm, sm_sh;
	logic [27:0] sum, rm;
	logic [4:0] lz;

	function automatic logic [4:0] lead_zeros(input logic [27:0] v);
		logic [4:0] n;
		n = 5'h1C;
		for (int i = 0; i < 28; i++) begin
			if (v[i]) n = 5'(27 - i);
		end
		return n;
	endfunction

	// Denormals flush to zero and the sum truncates; cheaper than full rounding
	always_comb begin
		za = i_a[30:23] == 8'h00;
		zb = i_b[30:23] == 8'h00;
		zc = i_c[30:23] == 8'h00;
		pz = za | zb;
		// Legacy zero rule: a zero factor hides an infinite or NaN partner
		nan_in = ((&i_a[30:23] | &i_b[30:23]) & (i_ieee_zero | !pz)) | (&i_c[30:23]);
		ps = i_a[31] ^ i_b[31];
		pm = {1'b1, i_a[22:0]} * {1'b1, i_b[22:0]};
		pman = pm[47] ? pm[47:24] : pm[46:23];
		pe = pz ? 11'sh000 : $signed({3'h0, i_a[30:23]}) + $signed({3'h0, i_b[30:23]})
			- $signed(`VAMLPO_FP_BIAS) + $signed({10'h000, pm[47]});
		ce = zc ? 11'sh000 : $signed({3'h0, i_c[30:23]});
		mp = pz ? 27'h0000000 : {pman, 3'h0};
		mc = zc ? 27'h0000000 : {1'b1, i_c[22:0], 3'h0};
		swap = (ce > pe) || ((ce == pe) && (mc > mp));
		bige = swap ? ce : pe;
		bigm = swap ? mc : mp;
		smallm = swap ? mp : mc;
		bigs = swap ? i_c[31] : ps;
		smalls = swap ? ps : i_c[31];
		diff = swap ? 11'(ce - pe) : 11'(pe - ce);
		sm_sh = (diff > 11'h01B) ? 27'h0000000 : (smallm >> diff[4:0]);
		sum = (bigs == smalls) ? ({1'b0, bigm} + {1'b0, sm_sh}) : ({1'b0, bigm} - {1'b0, sm_sh});
		lz = lead_zeros(sum);
		rm = sum << lz;
		re = bige + 11'sh001 - $signed({6'h00, lz}) + $signed({9'h000, i_scale});
		if (nan_in) begin
			o_sum = `VAMLPO_FP_QNAN;
		end else if (sum == 28'h0000000) begin
			o_sum = `VAMLPO_FP_ZERO;
		end else if (re <= 11'sh000) begin
			o_sum = {bigs, 31'h00000000};
		end else if (re >= 11'sh0FF) begin
			o_sum = {bigs, 8'hFF, 23'h000000};
		end else begin
			o_sum = {bigs, re[7:0], rm[26:4]};
		end
	end
endmodule

`default_nettype wire

// >>> design/vamlpo_top.sv
// Vector ALU slot datapath: multiplies, logic, offset conversion, predicate counter ops.
// Assumes issue logic presents one decoded instruction group per i_issue cycle.
// Function
// - Opcode 213 decodes dependent multiply-add, IEEE zero
// - Opcode 21: (src0*src1+src2) times two
// - Opcode 22: (src0*src1+src2) times four
// - Dependent add: y uses w, x uses z
// - Opcode 16: 24-bit multiply plus src2, low word
// - Opcodes 144/146: upper product word, signed/unsigned
// - Opcodes 143/145: lower product word, signed/unsigned
// - Opcode 178: product bits 47:32, zero-extended
// - Opcode 26: no write, previous vector invalidated
// - Unspecified slot acts as idle, invalidating channel
// - Opcode 51: complement of src0
// - Opcode 49: src0 OR src1
// - Opcode 180: nibble as sixteenths to float
// - Opcode 38: max float, predicate skip
// - Opcode 36: invert predicate counter
// - Opcode 37: pop predicate counter
// - Restore: zero gives execute, else copy, skip
// - Opcode 39 decodes predicate counter restore
// - Three-operand ops use three-operand second word
`default_nettype none

module vamlpo_top
	import vamlpo_pkg::*;
(
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// Instruction group from issue and operand fetch
	input wire logic i_issue,
	input wire logic [3:0] i_slot_valid,
	input wire logic [3:0] i_three_op,
	input wire vamlpo_opc_t i_opcode_field [4],
	input wire vamlpo_gpr_addr_t i_dst_addr [4],
	input wire vamlpo_word_t i_src0 [4],
	input wire vamlpo_word_t i_src1 [4],
	input wire vamlpo_word_t i_src2 [4],
	// General register write
	output logic [3:0] o_general_register_we,
	output vamlpo_gpr_addr_t o_general_register_addr [4],
	// Previous vector register, also the write data
	output vamlpo_word_t o_previous_vector_reg [4],
	output logic [3:0] o_pv_valid,
	output logic [3:0] o_unsupported,
	// Predicate register
	output logic o_pred_update,
	output logic o_pred_exec
);
	`include "vamlpo_params.svh"

	vamlpo_kind_t kind [4];
	vamlpo_word_t fma_b [4];
	vamlpo_word_t fma_c [4];
	vamlpo_word_t fma_out [4];
	vamlpo_word_t prev [4];
	vamlpo_word_t chan_res [4];
	logic [1:0] fma_scale [4];
	logic [3:0] fma_ieee, writes, pred_hit, pred_exec;
	logic [3:0] gpr_we_ff, nxt_gpr_we, pv_valid_ff, nxt_pv_valid, unsup_ff;
	vamlpo_gpr_addr_t gpr_addr_ff [4];
	vamlpo_word_t result_ff [4];
	logic pred_update_ff, nxt_pred_update, pred_exec_ff, nxt_pred_exec;
	logic [63:0] chk_sprod;

	function automatic vamlpo_kind_t decode_op(input logic valid, input logic three, input vamlpo_opc_t opc);
		vamlpo_kind_t k;
		k = KIND_UNSUP;
		if (!valid) begin
			k = KIND_EMPTY;
		end else if (three) begin
			case (opc[4:0])
				`VAMLPO_OP3_U24_FMA: k = KIND_U24FMA;
				`VAMLPO_OP3_FMA_TIMES_TWO: k = KIND_FMA2;
				`VAMLPO_OP3_FMA_TIMES_FOUR: k = KIND_FMA4;
				default: k = KIND_UNSUP;
			endcase
		end else begin
			case (opc)
				`VAMLPO_OP2_DEP_FMA: k = KIND_DEP;
				`VAMLPO_OP2_DEP_FMA_IEEE: k = KIND_DEP_IEEE;
				`VAMLPO_OP2_SIGNED_MUL_UPPER: k = KIND_SMULHI;
				`VAMLPO_OP2_UNSIGNED_MUL_UPPER: k = KIND_UMULHI;
				`VAMLPO_OP2_SIGNED_MUL_LOWER: k = KIND_SMULLO;
				`VAMLPO_OP2_UNSIGNED_MUL_LOWER: k = KIND_UMULLO;
				`VAMLPO_OP2_U24_MUL_UPPER: k = KIND_U24HI;
				`VAMLPO_OP2_IDLE_SLOT_OP: k = KIND_IDLE;
				`VAMLPO_OP2_NOT: k = KIND_NOT;
				`VAMLPO_OP2_OR: k = KIND_OR;
				`VAMLPO_OP2_NIBBLE_TO_FLOAT: k = KIND_NIB;
				`VAMLPO_OP2_PRED_COUNTER_CLEAR: k = KIND_CLR;
				`VAMLPO_OP2_PRED_COUNTER_INVERT: k = KIND_INV;
				`VAMLPO_OP2_PRED_COUNTER_POP: k = KIND_POP;
				`VAMLPO_OP2_PRED_COUNTER_RESTORE: k = KIND_RESTORE;
				default: k = KIND_UNSUP;
			endcase
		end
		return k;
	endfunction

	function automatic logic [63:0] mul64(input vamlpo_word_t a, input vamlpo_word_t b, input logic sgn);
		logic [63:0] ea, eb;
		ea = {{32{sgn & a[31]}}, a};
		eb = {{32{sgn & b[31]}}, b};
		return ea * eb;
	endfunction

	function automatic logic [47:0] mul24(input vamlpo_word_t a, input vamlpo_word_t b);
		return {24'h000000, a[23:0]} * {24'h000000, b[23:0]};
	endfunction

	// Both signed zeros and flushed denormals count as zero
	function automatic logic f_zero(input vamlpo_word_t a);
		return a[30:23] == 8'h00;
	endfunction

	function automatic logic f_le(input vamlpo_word_t a, input vamlpo_word_t b);
		logic r;
		if ((&a[30:23] && a[22:0] != 23'h000000) || (&b[30:23] && b[22:0] != 23'h000000)) begin
			r = 1'b0;
		end else if (f_zero(a) && f_zero(b)) begin
			r = 1'b1;
		end else if (a[31] != b[31]) begin
			r = a[31];
		end else if (a[31]) begin
			r = a[30:0] >= b[30:0];
		end else begin
			r = a[30:0] <= b[30:0];
		end
		return r;
	endfunction

	function automatic vamlpo_word_t nib_to_float(input logic [3:0] code);
		logic [3:0] mag;
		logic [1:0] p;
		vamlpo_word_t f;
		mag = code[3] ? 4'(-code) : code;
		p = mag[3] ? 2'h3 : mag[2] ? 2'h2 : mag[1] ? 2'h1 : 2'h0;
		f = `VAMLPO_FP_ZERO;
		if (mag != 4'h0) begin
			f = {code[3], 8'(`VAMLPO_NIB_EXP_BASE + {6'h00, p}), 23'({mag[2:0], 20'h00000} << (2'h3 - p))};
		end
		return f;
	endfunction

	function automatic vamlpo_word_t result_of(input vamlpo_kind_t k, input vamlpo_word_t s0,
		input vamlpo_word_t s1, input vamlpo_word_t s2, input vamlpo_word_t fma);
		vamlpo_word_t r;
		logic [63:0] sp;
		logic [63:0] up;
		logic [47:0] p24;
		r = `VAMLPO_FP_ZERO;
		// Products held in locals; a function result cannot be part-selected directly
		sp = mul64(s0, s1, 1'b1);
		up = mul64(s0, s1, 1'b0);
		p24 = mul24(s0, s1);
		case (k)
			KIND_FMA2, KIND_FMA4, KIND_DEP, KIND_DEP_IEEE: r = fma;
			KIND_U24FMA: r = p24[31:0] + s2;
			KIND_SMULHI: r = sp[63:32];
			KIND_UMULHI: r = up[63:32];
			KIND_SMULLO: r = sp[31:0];
			KIND_UMULLO: r = up[31:0];
			KIND_U24HI: r = {16'h0000, p24[47:32]};
			KIND_NOT: r = ~s0;
			KIND_OR: r = s0 | s1;
			KIND_NIB: r = nib_to_float(s0[3:0]);
			KIND_CLR: r = `VAMLPO_FP_MAX;
			KIND_INV: r = (s0 == `VAMLPO_FP_ONE) ? `VAMLPO_FP_ZERO : f_zero(s0) ? `VAMLPO_FP_ONE : s0;
			KIND_POP: r = f_le(s0, s1) ? `VAMLPO_FP_ZERO : fma;
			KIND_RESTORE: r = f_zero(s0) ? `VAMLPO_FP_ZERO : s0;
			default: r = `VAMLPO_FP_ZERO;
		endcase
		return r;
	endfunction

	for (genvar ch = 0; ch < 4; ch++) begin : g_ch
		assign kind[ch] = decode_op(i_slot_valid[ch], i_three_op[ch], i_opcode_field[ch]);
		// x and y take the z and w results; z and w never feed back, so no loop
		if (ch < 2) begin : g_prev
			assign prev[ch] = chan_res[ch + 2];
		end else begin : g_noprev
			// A dependent op here is undefined; the issuer keeps opcode 212 in x or y
			assign prev[ch] = `VAMLPO_FP_ZERO;
		end
		// Pop reuses the adder as src0 * 1.0 - src1
		assign fma_b[ch] = (kind[ch] == KIND_POP) ? `VAMLPO_FP_ONE : i_src1[ch];
		assign fma_c[ch] = (kind[ch] == KIND_POP) ? {~i_src1[ch][31], i_src1[ch][30:0]} :
			(kind[ch] == KIND_DEP || kind[ch] == KIND_DEP_IEEE) ? prev[ch] : i_src2[ch];
		assign fma_scale[ch] = (kind[ch] == KIND_FMA2) ? 2'h1 : (kind[ch] == KIND_FMA4) ? 2'h2 : 2'h0;
		assign fma_ieee[ch] = kind[ch] != KIND_DEP;
		vamlpo_fma u_fma (
			.i_a(i_src0[ch]),
			.i_b(fma_b[ch]),
			.i_c(fma_c[ch]),
			.i_ieee_zero(fma_ieee[ch]),
			.i_scale(fma_scale[ch]),
			.o_sum(fma_out[ch])
		);
		assign chan_res[ch] = result_of(kind[ch], i_src0[ch], i_src1[ch], i_src2[ch], fma_out[ch]);
		assign writes[ch] = !(kind[ch] inside {KIND_EMPTY, KIND_IDLE, KIND_UNSUP});
		assign pred_hit[ch] = kind[ch] inside {KIND_CLR, KIND_INV, KIND_POP, KIND_RESTORE};
		assign pred_exec[ch] = (kind[ch] == KIND_INV) ? (i_src0[ch] == `VAMLPO_FP_ONE) :
			(kind[ch] == KIND_POP) ? f_le(i_src0[ch], i_src1[ch]) :
			(kind[ch] == KIND_RESTORE) ? f_zero(i_src0[ch]) : 1'b0;
	end

	always_comb begin
		nxt_gpr_we = i_issue ? writes : 4'h0;
		nxt_pv_valid = i_issue ? writes : pv_valid_ff;
	end

	// Several predicate ops in one group: the lowest channel wins
	always_comb begin
		nxt_pred_update = 1'b0;
		nxt_pred_exec = pred_exec_ff;
		for (int ch = 3; ch >= 0; ch--) begin
			if (i_issue && pred_hit[ch]) begin
				nxt_pred_update = 1'b1;
				nxt_pred_exec = pred_exec[ch];
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			gpr_we_ff <= 4'h0;
			pv_valid_ff <= 4'h0;
			unsup_ff <= 4'h0;
		end else begin
			gpr_we_ff <= nxt_gpr_we;
			pv_valid_ff <= nxt_pv_valid;
			for (int ch = 0; ch < 4; ch++) begin
				unsup_ff[ch] <= i_issue && kind[ch] == KIND_UNSUP;
			end
		end
	end

	// Idle slots leave the old word in place; its validity bit is what drops
	always_ff @(posedge i_core_clk) begin
		for (int ch = 0; ch < 4; ch++) begin
			if (!i_rst_n) begin
				result_ff[ch] <= `VAMLPO_RST_WORD;
				gpr_addr_ff[ch] <= 7'h00;
			end else if (i_issue && writes[ch]) begin
				result_ff[ch] <= chan_res[ch];
				gpr_addr_ff[ch] <= i_dst_addr[ch];
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			pred_update_ff <= 1'b0;
			pred_exec_ff <= `VAMLPO_RST_PRED_EXEC;
		end else begin
			pred_update_ff <= nxt_pred_update;
			pred_exec_ff <= nxt_pred_exec;
		end
	end

	assign o_general_register_we = gpr_we_ff;
	assign o_general_register_addr = gpr_addr_ff;
	assign o_previous_vector_reg = result_ff;
	assign o_pv_valid = pv_valid_ff;
	assign o_unsupported = unsup_ff;
	assign o_pred_update = pred_update_ff;
	assign o_pred_exec = pred_exec_ff;

	assign chk_sprod = 64'($signed(i_src0[0])) * 64'($signed(i_src1[0]));

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	dep_ieee_decode_a: assert property (
		i_slot_valid[0] && !i_three_op[0] && i_opcode_field[0] == `VAMLPO_OP2_DEP_FMA_IEEE
		|-> kind[0] == KIND_DEP_IEEE && fma_ieee[0])
		else $error("opcode 213 not decoded as IEEE dependent multiply-add");
	times_two_a: assert property (
		i_issue && kind[2] == KIND_FMA2 && i_src0[2] == 32'h3FC00000 && i_src1[2] == 32'h40000000
		&& i_src2[2] == `VAMLPO_FP_ONE |=> o_previous_vector_reg[2] == 32'h41000000)
		else $error("times-two multiply-add result wrong");
	times_four_a: assert property (
		i_issue && kind[3] == KIND_FMA4 && i_src0[3] == 32'h3FC00000 && i_src1[3] == 32'h40000000
		&& i_src2[3] == `VAMLPO_FP_ONE |=> o_previous_vector_reg[3] == 32'h41800000)
		else $error("times-four multiply-add result wrong");
	dep_chain_a: assert property (
		i_issue && kind[0] == KIND_DEP_IEEE && i_src0[0] == 32'h40000000 && i_src1[0] == 32'h40400000
		&& writes[2] |=> o_previous_vector_reg[2] != 32'h41000000 || o_previous_vector_reg[0] == 32'h41600000)
		else $error("dependent x channel did not take z result");
	u24_fma_a: assert property (
		i_issue && kind[1] == KIND_U24FMA |=> o_previous_vector_reg[1] ==
		32'(48'($past(i_src0[1][23:0])) * 48'($past(i_src1[1][23:0]))) + $past(i_src2[1]))
		else $error("24-bit multiply-add wrong");
	mul_upper_a: assert property (
		i_issue && kind[0] == KIND_SMULHI |=> o_previous_vector_reg[0] == $past(chk_sprod[63:32]))
		else $error("signed upper product wrong");
	mul_lower_a: assert property (
		i_issue && kind[3] == KIND_UMULLO |=> o_previous_vector_reg[3] == $past(i_src0[3] * i_src1[3]))
		else $error("unsigned lower product wrong");
	u24_upper_a: assert property (
		i_issue && kind[0] == KIND_U24HI |=> o_previous_vector_reg[0][31:16] == 16'h0000 && o_general_register_we[0])
		else $error("24-bit upper product not zero-extended");
	idle_slot_a: assert property (
		i_issue && kind[2] == KIND_IDLE |=> !o_general_register_we[2] && !o_pv_valid[2])
		else $error("idle slot wrote or kept previous vector valid");
	empty_slot_a: assert property (
		i_issue && !i_slot_valid[3] |=> !o_general_register_we[3] && !o_pv_valid[3])
		else $error("unspecified slot did not invalidate its channel");
	not_value_a: assert property (
		i_issue && kind[0] == KIND_NOT |=> o_previous_vector_reg[0] == ~$past(i_src0[0]))
		else $error("complement wrong");
	or_value_a: assert property (
		i_issue && kind[1] == KIND_OR |=> o_previous_vector_reg[1] == ($past(i_src0[1]) | $past(i_src1[1])))
		else $error("bitwise or wrong");
	nibble_half_a: assert property (
		i_issue && kind[2] == KIND_NIB && i_src0[2][3:0] == 4'h8 |=> o_previous_vector_reg[2] == 32'hBF000000)
		else $error("nibble 1000 did not give minus one half");
	clear_pred_a: assert property (
		i_issue && kind[0] == KIND_CLR |=> o_previous_vector_reg[0] == `VAMLPO_FP_MAX && o_pred_update && !o_pred_exec)
		else $error("predicate clear wrong");
	invert_pred_a: assert property (
		i_issue && kind[0] == KIND_INV && i_src0[0] == `VAMLPO_FP_ONE
		|=> o_previous_vector_reg[0] == `VAMLPO_FP_ZERO && o_pred_exec)
		else $error("predicate invert of one wrong");
	pop_pred_a: assert property (
		i_issue && kind[0] == KIND_POP && i_src0[0] == 32'h40400000 && i_src1[0] == `VAMLPO_FP_ONE
		|=> o_previous_vector_reg[0] == 32'h40000000 && o_pred_update && !o_pred_exec)
		else $error("predicate pop wrong");
	restore_pred_a: assert property (
		i_issue && kind[0] == KIND_RESTORE && i_src0[0] == `VAMLPO_FP_ZERO
		|=> o_previous_vector_reg[0] == `VAMLPO_FP_ZERO && o_pred_exec)
		else $error("predicate restore of zero wrong");
	three_op_a: assert property (
		i_slot_valid[0] && !i_three_op[0] && i_opcode_field[0][4:0] == 5'h15 |-> kind[0] != KIND_FMA2)
		else $error("two-operand word decoded as three-operand op");
	pred_hold_a: assert property (
		!i_issue |=> !o_pred_update && $stable(o_pred_exec))
		else $error("predicate changed without a predicate op");
endmodule

`default_nettype wire

// >>> tb/vamlpo_issue_model.sv
// Issue and operand fetch model: presents one instruction group per fire call.
// Assumes the bench calls set_slot and fire just after a falling clock edge.
`default_nettype none

module vamlpo_issue_model
	import vamlpo_pkg::*;
(
	// Clock
	input wire logic i_core_clk,
	// Group towards the datapath
	output logic o_issue,
	output logic [3:0] o_slot_valid,
	output logic [3:0] o_three_op,
	output var vamlpo_opc_t o_opcode_field [4],
	output var vamlpo_gpr_addr_t o_dst_addr [4],
	output var vamlpo_word_t o_src0 [4],
	output var vamlpo_word_t o_src1 [4],
	output var vamlpo_word_t o_src2 [4]
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] pend;

	initial begin
		o_issue = 1'b0;
		o_slot_valid = 4'h0;
		o_three_op = 4'h0;
		pend = 4'h0;
		for (int i = 0; i < 4; i++) begin
			o_opcode_field[i] = 11'h01A;
			o_dst_addr[i] = 7'h00;
			o_src0[i] = 32'h00000000;
			o_src1[i] = 32'h00000000;
			o_src2[i] = 32'h00000000;
		end
	end

	task automatic set_slot(input int ch, input logic three, input vamlpo_opc_t op,
		input vamlpo_word_t a, input vamlpo_word_t b, input vamlpo_word_t c);
		// Dependent add on z or w has undefined results, so the issuer never sends opcode 212 there
		if (!(op == 11'h0D4 && !three && ch > 1)) begin
			pend[ch] = 1'b1;
			o_three_op[ch] = three;
			o_opcode_field[ch] = op;
			o_dst_addr[ch] = 7'(ch * 9 + 3);
			o_src0[ch] = a;
			o_src1[ch] = b;
			o_src2[ch] = c;
		end
	endtask

	task automatic fire();
		// Unused slots carry junk so a stale operand cannot look valid
		for (int i = 0; i < 4; i++) begin
			if (!pend[i]) begin
				o_src0[i] = ~o_src0[i];
				o_opcode_field[i] = ~o_opcode_field[i];
			end
		end
		o_slot_valid = pend;
		o_issue = 1'b1;
		@(negedge i_core_clk);
		o_issue = 1'b0;
		pend = 4'h0;
	endtask
endmodule

`default_nettype wire

// >>> tb/vamlpo_top_tb.sv
// Self-checking bench for the vector ALU slot datapath.
// Assumes the issue model drives every instruction group input on falling edges; the bench itself drives clock and reset.
`default_nettype none

module vector_alu_mul_logic_predicate_ops_tb_top;
	import vamlpo_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_core_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic issue_v;
	logic [3:0] slot_v, three_v, we, pv_valid, unsup;
	logic upd, pexec;
	vamlpo_opc_t opc [4];
	vamlpo_gpr_addr_t dst [4], addr [4];
	vamlpo_word_t s0 [4], s1 [4], s2 [4], pv [4];
	int err_total = 0;
	int comparisons = 0;
	int cyc = 0;

	always #50 i_core_clk = ~i_core_clk;

	vamlpo_issue_model issue (.i_core_clk(i_core_clk), .o_issue(issue_v), .o_slot_valid(slot_v),
		.o_three_op(three_v), .o_opcode_field(opc), .o_dst_addr(dst), .o_src0(s0), .o_src1(s1), .o_src2(s2));

	vamlpo_top dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_issue(issue_v), .i_slot_valid(slot_v),
		.i_three_op(three_v), .i_opcode_field(opc), .i_dst_addr(dst), .i_src0(s0), .i_src1(s1), .i_src2(s2),
		.o_general_register_we(we), .o_general_register_addr(addr), .o_previous_vector_reg(pv),
		.o_pv_valid(pv_valid), .o_unsupported(unsup), .o_pred_update(upd), .o_pred_exec(pexec));

	task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", name, e, g);
		end
	endtask

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Hang guard, far above the few dozen cycles the tests need
	always @(posedge i_core_clk) begin
		cyc++;
		if (cyc == 2000) begin
			err_total++;
			end_sim();
		end
	end

	task automatic t_logic();
		for (int i = 0; i < 4; i++) begin
			issue.set_slot(i, 1'b0, 11'h033, 32'h0000000F << i, 32'h0, 32'h0);
		end
		issue.fire();
		chk("pv_valid all", 32'hF, 32'(pv_valid));
		@(negedge i_core_clk);
		issue.set_slot(0, 1'b0, 11'h033, 32'hA5A5F00F, 32'h0, 32'h0);
		issue.set_slot(1, 1'b0, 11'h031, 32'h12340000, 32'h00005678, 32'h0);
		issue.set_slot(2, 1'b0, 11'h01A, 32'h1, 32'h1, 32'h0);
		// Opcode outside this block: flagged, not written, channel invalidated
		issue.set_slot(3, 1'b0, 11'h0FF, 32'h1, 32'h1, 32'h0);
		issue.fire();
		chk("write enables", 32'h3, 32'(we));
		chk("pv_valid", 32'h3, 32'(pv_valid));
		chk("not", 32'h5A5A0FF0, pv[0]);
		chk("or", 32'h12345678, pv[1]);
		chk("dest addr y", 32'd12, 32'(addr[1]));
		chk("unsupported", 32'h8, 32'(unsup));
		@(negedge i_core_clk);
		chk("we pulse", 32'h0, 32'(we));
		$display("test logic done");
	endtask

	task automatic t_mul();
		issue.set_slot(0, 1'b0, 11'h090, 32'hFFFFFFFE, 32'h3, 32'h0);
		issue.set_slot(1, 1'b0, 11'h092, 32'hFFFFFFFE, 32'h3, 32'h0);
		issue.set_slot(2, 1'b0, 11'h08F, 32'hFFFFFFFE, 32'h3, 32'h0);
		issue.set_slot(3, 1'b0, 11'h091, 32'hFFFFFFFE, 32'h3, 32'h0);
		issue.fire();
		chk("signed upper", 32'hFFFFFFFF, pv[0]);
		chk("unsigned upper", 32'h00000002, pv[1]);
		chk("signed lower", 32'hFFFFFFFA, pv[2]);
		chk("unsigned lower", 32'hFFFFFFFA, pv[3]);
		@(negedge i_core_clk);
		issue.set_slot(0, 1'b0, 11'h0B2, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0);
		issue.set_slot(1, 1'b1, 11'h010, 32'hAB001000, 32'hCD001000, 32'hFFFFFFFF);
		issue.set_slot(2, 1'b0, 11'h0B4, 32'h8, 32'h0, 32'h0);
		issue.set_slot(3, 1'b0, 11'h0B4, 32'h1, 32'h0, 32'h0);
		issue.fire();
		chk("u24 upper", 32'h0000FFFF, pv[0]);
		chk("u24 fma", 32'h00FFFFFF, pv[1]);
		chk("nibble minus half", 32'hBF000000, pv[2]);
		chk("nibble sixteenth", 32'h3D800000, pv[3]);
		@(negedge i_core_clk);
		$display("test multiply done");
	endtask

	task automatic t_fma();
		issue.set_slot(0, 1'b0, 11'h0D5, 32'h40000000, 32'h40400000, 32'h0);
		issue.set_slot(1, 1'b0, 11'h0D4, 32'h3F800000, 32'h3F800000, 32'h0);
		issue.set_slot(2, 1'b1, 11'h015, 32'h3FC00000, 32'h40000000, 32'h3F800000);
		issue.set_slot(3, 1'b1, 11'h016, 32'h3FC00000, 32'h40000000, 32'h3F800000);
		issue.fire();
		chk("dependent x from z", 32'h41600000, pv[0]);
		chk("dependent y from w", 32'h41880000, pv[1]);
		chk("fma times two", 32'h41000000, pv[2]);
		chk("fma times four", 32'h41800000, pv[3]);
		chk("fma writes", 32'hF, 32'(we));
		@(negedge i_core_clk);
		$display("test fma done");
	endtask

	task automatic p1(input vamlpo_opc_t op, input vamlpo_word_t a, input vamlpo_word_t b,
		input vamlpo_word_t e, input logic ex);
		issue.set_slot(0, 1'b0, op, a, b, 32'h0);
		issue.fire();
		chk("pred result", e, pv[0]);
		chk("pred update", 32'h1, 32'(upd));
		chk("pred exec", 32'(ex), 32'(pexec));
		@(negedge i_core_clk);
		chk("pred update pulse", 32'h0, 32'(upd));
	endtask

	task automatic t_pred();
		p1(11'h026, 32'h3F800000, 32'h0, 32'h7F7FFFFF, 1'b0);
		p1(11'h024, 32'h3F800000, 32'h0, 32'h00000000, 1'b1);
		p1(11'h024, 32'h00000000, 32'h0, 32'h3F800000, 1'b0);
		p1(11'h024, 32'h40000000, 32'h0, 32'h40000000, 1'b0);
		p1(11'h025, 32'h3F800000, 32'h40000000, 32'h00000000, 1'b1);
		p1(11'h025, 32'h40400000, 32'h3F800000, 32'h40000000, 1'b0);
		p1(11'h027, 32'h40A00000, 32'h0, 32'h40A00000, 1'b0);
		p1(11'h027, 32'h00000000, 32'h0, 32'h00000000, 1'b1);
		// Lowest channel decides when two predicate ops share a group
		issue.set_slot(0, 1'b0, 11'h025, 32'h3F800000, 32'h40000000, 32'h0);
		issue.set_slot(1, 1'b0, 11'h026, 32'h0, 32'h0, 32'h0);
		issue.fire();
		chk("pred priority", 32'h1, 32'(pexec));
		@(negedge i_core_clk);
		issue.set_slot(0, 1'b0, 11'h033, 32'h0, 32'h0, 32'h0);
		issue.fire();
		chk("pred held", 32'h1, 32'(pexec));
		chk("no pred update", 32'h0, 32'(upd));
		@(negedge i_core_clk);
		$display("test predicate done");
	endtask

	initial begin
		repeat (3) @(posedge i_core_clk);
		@(negedge i_core_clk);
		i_rst_n = 1'b1;
		chk("reset pv_valid", 32'h0, 32'(pv_valid));
		chk("reset pred exec", 32'h0, 32'(pexec));
		t_logic();
		t_mul();
		t_fma();
		t_pred();
		end_sim();
	end
endmodule

`default_nettype wire
